// [shared/dword_exec_pkg.sv]
/*
 * Shared constants and carrier types for the doubleword shift and subtract unit.
 * Assumes a decode stage that supplies the raw instruction word and both register operands.
 */
`default_nettype none

package dword_exec_pkg;

    // ************************************************************
    // Instruction field positions and encodings
    // ************************************************************
    localparam int OPC_HI   = 31;
    localparam int OPC_LO   = 26;
    localparam int PRI_HI   = 25;
    localparam int PRI_LO   = 21;
    localparam int SEC_HI   = 20;
    localparam int SEC_LO   = 16;
    localparam int DST_HI   = 15;
    localparam int DST_LO   = 11;
    localparam int SHA_HI   = 10;
    localparam int SHA_LO   = 6;
    localparam int FUNC_HI  = 5;
    localparam int FUNC_LO  = 0;

    localparam logic [5:0] OPC_SPECIAL        = 6'h00;
    localparam logic [4:0] FIELD_ZERO         = 5'h00;
    localparam logic [5:0] FN_SHL_IMM         = 6'h38;
    localparam logic [5:0] FN_SHL_IMM_HI      = 6'h3C;
    localparam logic [5:0] FN_SHL_VAR         = 6'h14;
    localparam logic [5:0] FN_SAR_IMM         = 6'h3B;
    localparam logic [5:0] FN_SAR_IMM_HI      = 6'h3F;
    localparam logic [5:0] FN_SAR_VAR         = 6'h17;
    localparam logic [5:0] FN_SHR_IMM         = 6'h3A;
    localparam logic [5:0] FN_SHR_IMM_HI      = 6'h3E;
    localparam logic [5:0] FN_SHR_VAR         = 6'h16;
    localparam logic [5:0] FN_SUB_TRAP        = 6'h2E;
    localparam logic [5:0] FN_SUB_WRAP        = 6'h2F;

    localparam int         DWORD_W            = 64;
    localparam int         SIGN_BIT           = 63;
    localparam logic [63:0] RESULT_RST        = 64'h0000_0000_0000_0000;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef enum logic [1:0] {SH_LEFT, SH_RIGHT_LOG, SH_RIGHT_ARI} shift_dir_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] instr;
        logic [63:0] primary_operand;
        logic [63:0] secondary_operand;
    } issue_t;

    typedef struct packed {
        logic        wr_en;
        logic [4:0]  wr_addr;
        logic [63:0] wr_data;
        logic        ovf_exc;
        logic        rsvd_exc;
    } retire_t;

endpackage

`default_nettype wire

// [logic/dword_barrel_shift.sv]
/*
 * Combinational 64-bit barrel shifter for left, logical right and arithmetic right.
 * Assumes the caller has already formed the 6-bit amount.
 */
`default_nettype none

module dword_barrel_shift
    import dword_exec_pkg::*;
(
    input  wire logic [63:0] operand_i,
    input  wire logic [5:0]  amount_i,
    input  wire shift_dir_t  dir_i,
    output logic [63:0]      result_o
);

    wire logic [63:0] left_res;
    wire logic [63:0] right_log;
    wire logic [63:0] right_ari;

    assign left_res  = operand_i << amount_i;
    assign right_log = operand_i >> amount_i;
    assign right_ari = $unsigned($signed(operand_i) >>> amount_i);

    assign result_o = (dir_i == SH_LEFT)      ? left_res  :
                      (dir_i == SH_RIGHT_LOG) ? right_log : right_ari;

endmodule // dword_barrel_shift

`default_nettype wire

// [logic/dword_shift_subtract_unit.sv]
/*
 * Execute stage for doubleword shifts and subtracts; one result per cycle.
 * Assumes the decode stage presents one instruction with operands per clock.
 */
// Overview of operation
// [RQ1] Immediate left shift by field, zero fill.
// [RQ2] Function 111100: left shift by field plus 32.
// [RQ3] Function 010100: left shift by low six bits.
// [RQ4] Function 111011: arithmetic right shift by field.
// [RQ5] Function 111111: arithmetic right by field plus 32.
// [RQ6] Function 010111: arithmetic right by register amount.
// [RQ7] Function 111010: logical right shift by field.
// [RQ8] Function 111110: logical right by field plus 32.
// [RQ9] Function 010110: logical right by register amount.
// [RQ10] Function 101110: subtract, write only without overflow.
// [RQ11] Overflow from 65-bit bits 64,63 mismatch; trap.
// [RQ12] Function 101111: modulo subtract, never traps.
// [RQ13] Primary opcode zero; immediate shifts need zero field.
// [RQ14] Subtracts may raise reserved-instruction exception.
// [RQ15] One-cycle result, write enable off on exception.
`default_nettype none

module dword_shift_subtract_unit
    import dword_exec_pkg::*;
(
    input  wire logic   core_clk_i,
    input  wire logic   rst_b_i,
    input  wire issue_t issue_i,
    input  wire logic   rsvd_instr_i,
    output retire_t     retire_o
);

    // ************************************************************
    // Reset release
    // ************************************************************
    logic rst_sync1_reg;
    logic rst_b_reg;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync1_reg <= 1'b0;
            rst_b_reg     <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_b_reg     <= rst_sync1_reg;
        end
    end

    // ************************************************************
    // Decode
    // ************************************************************
    wire logic [5:0]  opcode;
    wire logic [4:0]  primary_operand_field;
    wire logic [4:0]  dst_field;
    wire logic [4:0]  shift_amount_field;
    wire logic [5:0]  func;
    wire logic        special;
    wire logic        pri_zero;
    wire logic        is_imm_shift;
    wire logic        is_var_shift;
    wire logic        is_sub_trap;
    wire logic        is_sub_wrap;
    wire logic        is_hi_form;
    wire logic        accept;

    assign opcode                = issue_i.instr[OPC_HI:OPC_LO];
    assign primary_operand_field = issue_i.instr[PRI_HI:PRI_LO];
    assign dst_field             = issue_i.instr[DST_HI:DST_LO];
    assign shift_amount_field    = issue_i.instr[SHA_HI:SHA_LO];
    assign func                  = issue_i.instr[FUNC_HI:FUNC_LO];
    assign special               = (opcode == OPC_SPECIAL);                          // RQ13
    assign pri_zero              = (primary_operand_field == FIELD_ZERO);            // RQ13

    assign is_hi_form   = (func == FN_SHL_IMM_HI) || (func == FN_SAR_IMM_HI) || (func == FN_SHR_IMM_HI);
    assign is_imm_shift = special && pri_zero && (is_hi_form || (func == FN_SHL_IMM)
                          || (func == FN_SAR_IMM) || (func == FN_SHR_IMM));           // RQ13
    assign is_var_shift = special && ((func == FN_SHL_VAR) || (func == FN_SAR_VAR)
                          || (func == FN_SHR_VAR));
    assign is_sub_trap  = special && (func == FN_SUB_TRAP);                          // RQ10
    assign is_sub_wrap  = special && (func == FN_SUB_WRAP);                          // RQ12
    assign accept       = issue_i.valid && (is_imm_shift || is_var_shift || is_sub_trap || is_sub_wrap);

    // ************************************************************
    // Shift path
    // ************************************************************
    wire logic [5:0]  sh_amount;
    wire shift_dir_t  sh_dir;
    wire logic [63:0] sh_result;

    // Immediate forms prefix a one bit for the plus-32 encodings.
    assign sh_amount = is_var_shift ? issue_i.primary_operand[5:0]                   // RQ3 RQ6 RQ9
                                    : {is_hi_form, shift_amount_field};              // RQ1 RQ2 RQ5 RQ8
    assign sh_dir = ((func == FN_SHL_IMM) || (func == FN_SHL_IMM_HI) || (func == FN_SHL_VAR)) ? SH_LEFT :
                    ((func == FN_SHR_IMM) || (func == FN_SHR_IMM_HI) || (func == FN_SHR_VAR))
                        ? SH_RIGHT_LOG : SH_RIGHT_ARI;                               // RQ4 RQ7

    dword_barrel_shift u_shift (
        .operand_i (issue_i.secondary_operand),
        .amount_i  (sh_amount),
        .dir_i     (sh_dir),
        .result_o  (sh_result)
    );

    // ************************************************************
    // Subtract path
    // ************************************************************
    wire logic [64:0] diff_wide;
    wire logic        overflow;
    wire logic        is_sub;

    assign diff_wide = {issue_i.primary_operand[SIGN_BIT], issue_i.primary_operand}
                     - {issue_i.secondary_operand[SIGN_BIT], issue_i.secondary_operand};
    assign overflow  = is_sub_trap && (diff_wide[64] != diff_wide[63]);              // RQ11
    assign is_sub    = is_sub_trap || is_sub_wrap;

    // ************************************************************
    // Retire
    // ************************************************************
    wire logic        rsvd_hit;
    wire logic        ovf_hit;
    wire retire_t     retire_next;
    retire_t          retire_reg;

    // Reserved-instruction is only reportable for the subtracts.
    assign rsvd_hit = accept && is_sub && rsvd_instr_i;                              // RQ14
    assign ovf_hit  = accept && overflow && !rsvd_hit;                               // RQ11

    assign retire_next.wr_en    = accept && !rsvd_hit && !ovf_hit;                   // RQ15 RQ10
    assign retire_next.wr_addr  = dst_field;
    assign retire_next.wr_data  = is_sub ? diff_wide[63:0] : sh_result;              // RQ12
    assign retire_next.ovf_exc  = ovf_hit;
    assign retire_next.rsvd_exc = rsvd_hit;

    always_ff @(posedge core_clk_i or negedge rst_b_reg) begin
        if (!rst_b_reg) begin
            retire_reg <= '{wr_en: 1'b0, wr_addr: 5'h00, wr_data: RESULT_RST, ovf_exc: 1'b0, rsvd_exc: 1'b0};
        end else begin
            retire_reg <= retire_next;
        end
    end

    assign retire_o = retire_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    a_wr_exc_excl: assert property (@(posedge core_clk_i) disable iff (!rst_b_reg) // RQ15
        (retire_o.ovf_exc || retire_o.rsvd_exc) |-> !retire_o.wr_en)
        else $error("write enable raised with an exception");

    a_ovf_trap_only: assert property (@(posedge core_clk_i) disable iff (!rst_b_reg) // RQ12
        (accept && is_sub_wrap) |=> !retire_o.ovf_exc)
        else $error("wrapping subtract raised overflow");

    a_sub_trap_ovf: assert property (@(posedge core_clk_i) disable iff (!rst_b_reg) // RQ11
        (accept && is_sub_trap && !rsvd_instr_i && (issue_i.primary_operand[63] != issue_i.secondary_operand[63])
         && (diff_wide[63] != issue_i.primary_operand[63])) |=> (retire_o.ovf_exc && !retire_o.wr_en))
        else $error("trapping subtract overflow missed");

    a_sub_trap_ok: assert property (@(posedge core_clk_i) disable iff (!rst_b_reg) // RQ10
        (accept && is_sub_trap && !rsvd_instr_i && !overflow)
        |=> (retire_o.wr_en && retire_o.wr_data == ($past(issue_i.primary_operand) - $past(issue_i.secondary_operand))))
        else $error("trapping subtract result wrong");

    a_shl_hi_val: assert property (@(posedge core_clk_i) disable iff (!rst_b_reg) // RQ2
        (accept && func == FN_SHL_IMM_HI)
        |=> (retire_o.wr_data == ($past(issue_i.secondary_operand) << (7'h20 + $past(shift_amount_field)))))
        else $error("left shift plus 32 wrong");

    a_sar_fill: assert property (@(posedge core_clk_i) disable iff (!rst_b_reg) // RQ4
        (accept && func == FN_SAR_IMM && issue_i.secondary_operand[63]) |=> retire_o.wr_data[63])
        else $error("arithmetic shift lost sign");

    a_shr_var_val: assert property (@(posedge core_clk_i) disable iff (!rst_b_reg) // RQ9
        (accept && func == FN_SHR_VAR)
        |=> (retire_o.wr_data == ($past(issue_i.secondary_operand) >> $past(issue_i.primary_operand[5:0]))))
        else $error("variable logical right shift wrong");

    a_imm_needs_zero: assert property (@(posedge core_clk_i) disable iff (!rst_b_reg) // RQ13
        (issue_i.valid && func == FN_SHL_IMM && !pri_zero) |=> !retire_o.wr_en)
        else $error("immediate shift accepted with nonzero field");

    a_one_cycle: assert property (@(posedge core_clk_i) disable iff (!rst_b_reg) // RQ15
        (accept && is_sub_wrap && !rsvd_instr_i) |=> (retire_o.wr_en && retire_o.wr_addr == $past(dst_field)))
        else $error("wrapping subtract did not retire next cycle");

    a_shl_imm_val: assert property (@(posedge core_clk_i) disable iff (!rst_b_reg) // RQ1
        (accept && func == FN_SHL_IMM)
        |=> (retire_o.wr_data == ($past(issue_i.secondary_operand) << $past(shift_amount_field))))
        else $error("immediate left shift wrong");

    a_shl_var_val: assert property (@(posedge core_clk_i) disable iff (!rst_b_reg) // RQ3
        (accept && func == FN_SHL_VAR)
        |=> (retire_o.wr_data == ($past(issue_i.secondary_operand) << $past(issue_i.primary_operand[5:0]))))
        else $error("variable left shift wrong");

    // A shift of at least 32 leaves the sign in the top 33 bits, whatever the field holds.
    a_sar_hi_fill: assert property (@(posedge core_clk_i) disable iff (!rst_b_reg) // RQ5
        (accept && func == FN_SAR_IMM_HI)
        |=> (retire_o.wr_data[63:31] == {33{$past(issue_i.secondary_operand[63])}}))
        else $error("arithmetic shift plus 32 lost sign fill");

    // The sign fill is built from a logical shift and a mask, so it does not lean on the shifter's own form.
    a_sar_var_val: assert property (@(posedge core_clk_i) disable iff (!rst_b_reg) // RQ6
        (accept && func == FN_SAR_VAR)
        |=> (retire_o.wr_data == (($past(issue_i.secondary_operand) >> $past(issue_i.primary_operand[5:0]))
             | ({64{$past(issue_i.secondary_operand[63])}}
                & ~(64'hFFFF_FFFF_FFFF_FFFF >> $past(issue_i.primary_operand[5:0]))))))
        else $error("variable arithmetic right shift wrong");

    a_shr_imm_val: assert property (@(posedge core_clk_i) disable iff (!rst_b_reg) // RQ7
        (accept && func == FN_SHR_IMM)
        |=> (retire_o.wr_data == ($past(issue_i.secondary_operand) >> $past(shift_amount_field))))
        else $error("immediate logical right shift wrong");

    a_shr_hi_val: assert property (@(posedge core_clk_i) disable iff (!rst_b_reg) // RQ8
        (accept && func == FN_SHR_IMM_HI)
        |=> (retire_o.wr_data == ($past(issue_i.secondary_operand) >> (7'h20 + $past(shift_amount_field)))))
        else $error("logical right shift plus 32 wrong");

    a_rsvd_sub: assert property (@(posedge core_clk_i) disable iff (!rst_b_reg) // RQ14
        (accept && is_sub && rsvd_instr_i)
        |=> (retire_o.rsvd_exc && !retire_o.ovf_exc && !retire_o.wr_en))
        else $error("reserved-instruction request on subtract not reported");

    a_rsvd_shift_none: assert property (@(posedge core_clk_i) disable iff (!rst_b_reg) // RQ14
        (accept && !is_sub && rsvd_instr_i) |=> (retire_o.wr_en && !retire_o.rsvd_exc))
        else $error("reserved-instruction request leaked onto a shift");

    a_opcode_gate: assert property (@(posedge core_clk_i) disable iff (!rst_b_reg) // RQ13
        (issue_i.valid && !special) |=> !(retire_o.wr_en || retire_o.ovf_exc || retire_o.rsvd_exc))
        else $error("instruction outside the primary opcode retired");

endmodule // dword_shift_subtract_unit

`default_nettype wire

// [tb/regfile_model.sv]
/*
 * Register file stand-in that sits behind the retire port and absorbs writes.
 * Assumes one retire record per core clock; counts writes and traps and sums every landed write.
 */
`default_nettype none

module regfile_model
    import dword_exec_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire retire_t     retire_i,
    output var  int          writes_o,
    output var  int          traps_o,
    output var  logic [63:0] sum_o
);
    timeunit 1ns;
    timeprecision 1ps;

    int          write_cnt = 0;
    int          trap_cnt  = 0;
    logic [63:0] sum_reg   = 64'h0;

    // Only a cleanly high write enable lands, so an unknown enable shows up as a missing write.
    // A running sum of address and data stands in for the register contents, so every landed write is weighed.
    always @(posedge core_clk_i) begin
        if (retire_i.wr_en === 1'b1) begin
            write_cnt <= write_cnt + 1;
            sum_reg   <= sum_reg + retire_i.wr_data + 64'(retire_i.wr_addr);
        end
        if (retire_i.ovf_exc === 1'b1) begin
            trap_cnt <= trap_cnt + 1;
        end
    end

    assign writes_o = write_cnt;
    assign traps_o  = trap_cnt;
    assign sum_o    = sum_reg;
endmodule // regfile_model

`default_nettype wire

// [tb/tb.sv]
/*
 * Self-checking bench for the doubleword shift and subtract unit.
 * Assumes one issue per clock and a registered result one clock later.
 */
`default_nettype none

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED time=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
    import dword_exec_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic       core_clk_i   = 1'b0;
    logic       rst_b_i      = 1'b0;
    issue_t     issue_i      = '0;
    logic       rsvd_instr_i = 1'b0;
    retire_t    retire_o;
    retire_t    pend         = '0;
    logic [5:0] pfn          = '0;
    logic [5:0] fn;
    int         failures     = 0;
    int         checks       = 0;
    int         seed         = 62190;
    int         writes;
    int         traps;
    logic [63:0] wr_sum;
    logic [63:0] exp_sum     = 64'h0;
    int         exp_writes   = 0;
    int         exp_traps    = 0;
    logic [5:0] fns [11]     = '{FN_SHL_IMM, FN_SHL_IMM_HI, FN_SHL_VAR, FN_SAR_IMM, FN_SAR_IMM_HI, FN_SAR_VAR,
                                 FN_SHR_IMM, FN_SHR_IMM_HI, FN_SHR_VAR, FN_SUB_TRAP, FN_SUB_WRAP};

    always #25 core_clk_i = ~core_clk_i;

    dword_shift_subtract_unit uut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .issue_i(issue_i),
                                   .rsvd_instr_i(rsvd_instr_i), .retire_o(retire_o));
    regfile_model partner (.core_clk_i(core_clk_i), .retire_i(retire_o), .writes_o(writes), .traps_o(traps),
                           .sum_o(wr_sum));

    // ************************************************************
    // Expectation and stimulus helpers
    // ************************************************************
    function automatic retire_t expect_of(issue_t iss, logic rsv);
        retire_t     r;
        logic [5:0]  f;
        logic [5:0]  s;
        logic [64:0] t;
        logic        imm;
        logic        sub;
        logic        ok;
        f   = iss.instr[FUNC_HI:FUNC_LO];
        imm = f inside {FN_SHL_IMM, FN_SHL_IMM_HI, FN_SAR_IMM, FN_SAR_IMM_HI, FN_SHR_IMM, FN_SHR_IMM_HI};
        sub = f inside {FN_SUB_TRAP, FN_SUB_WRAP};
        ok  = iss.valid && (iss.instr[OPC_HI:OPC_LO] == OPC_SPECIAL)
              && ((iss.instr[PRI_HI:PRI_LO] == FIELD_ZERO) || !imm)
              && (imm || sub || (f inside {FN_SHL_VAR, FN_SAR_VAR, FN_SHR_VAR}));
        s   = imm ? {f inside {FN_SHL_IMM_HI, FN_SAR_IMM_HI, FN_SHR_IMM_HI}, iss.instr[SHA_HI:SHA_LO]}
                  : iss.primary_operand[5:0];
        t   = {iss.primary_operand[63], iss.primary_operand} - {iss.secondary_operand[63], iss.secondary_operand};
        r   = '0;
        r.wr_addr = iss.instr[DST_HI:DST_LO];
        case (f)
            FN_SHL_IMM, FN_SHL_IMM_HI, FN_SHL_VAR: r.wr_data = iss.secondary_operand << s;
            FN_SHR_IMM, FN_SHR_IMM_HI, FN_SHR_VAR: r.wr_data = iss.secondary_operand >> s;
            FN_SAR_IMM, FN_SAR_IMM_HI, FN_SAR_VAR: r.wr_data = $signed(iss.secondary_operand) >>> s;
            default: r.wr_data = t[63:0];
        endcase
        r.rsvd_exc = ok && sub && rsv;
        r.ovf_exc  = ok && f == FN_SUB_TRAP && !rsv && t[64] != t[63];
        r.wr_en    = ok && !r.rsvd_exc && !r.ovf_exc;
        return r;
    endfunction

    function automatic logic [31:0] build_instr(logic [5:0] opc, logic [4:0] pri, logic [4:0] sa, logic [5:0] f);
        return {opc, pri, 5'h0B, 5'($random(seed)), sa, f};
    endfunction

    // Checks the result of the previous issue while presenting the next one.
    task automatic step(input logic v, input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b,
                        input logic rsv);
        issue_t nx;
        nx = '{valid: v, instr: ins, primary_operand: a, secondary_operand: b};
        @(posedge core_clk_i);
        issue_i      <= nx;
        rsvd_instr_i <= rsv;
        #1;
        `CHK(retire_o.wr_en, pend.wr_en)
        `CHK(retire_o.ovf_exc, pend.ovf_exc)
        `CHK(retire_o.rsvd_exc, pend.rsvd_exc)
        if (pend.wr_en) begin
            `CHK(retire_o.wr_addr, pend.wr_addr)
            case (pfn)
                FN_SHL_IMM:    `CHK(retire_o.wr_data, pend.wr_data)
                FN_SHL_IMM_HI: `CHK(retire_o.wr_data, pend.wr_data)
                FN_SHL_VAR:    `CHK(retire_o.wr_data, pend.wr_data)
                FN_SAR_IMM:    `CHK(retire_o.wr_data, pend.wr_data)
                FN_SAR_IMM_HI: `CHK(retire_o.wr_data, pend.wr_data)
                FN_SAR_VAR:    `CHK(retire_o.wr_data, pend.wr_data)
                FN_SHR_IMM:    `CHK(retire_o.wr_data, pend.wr_data)
                FN_SHR_IMM_HI: `CHK(retire_o.wr_data, pend.wr_data)
                FN_SHR_VAR:    `CHK(retire_o.wr_data, pend.wr_data)
                FN_SUB_TRAP:   `CHK(retire_o.wr_data, pend.wr_data)
                default:       `CHK(retire_o.wr_data, pend.wr_data)
            endcase
        end
        pend       = expect_of(nx, rsv);
        pfn        = ins[FUNC_HI:FUNC_LO];
        exp_writes += pend.wr_en;
        exp_traps  += pend.ovf_exc;
        if (pend.wr_en) begin
            exp_sum += pend.wr_data + 64'(pend.wr_addr);
        end
    endtask

    task automatic results();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (4) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
    end

    initial begin
        repeat (50000) @(posedge core_clk_i);
        failures++;
        results();
    end

    initial begin
        repeat (6) step(1'b0, 32'h0, 64'h0, 64'h0, 1'b0);
        foreach (fns[i]) begin
            step(1'b1, build_instr(OPC_SPECIAL, 5'h00, 5'h00, fns[i]), 64'hFFFF_FFFF_FFFF_FFC0,
                 64'h8000_0000_0000_0001, 1'b0);
            step(1'b1, build_instr(OPC_SPECIAL, 5'h00, 5'h1F, fns[i]), 64'hFFFF_FFFF_FFFF_FFFF,
                 64'hC000_0000_0000_0003, 1'b1);
        end
        $display("test boundary shifts done");
        step(1'b1, build_instr(OPC_SPECIAL, 5'h02, 5'h00, FN_SUB_TRAP), 64'h7FFF_FFFF_FFFF_FFFF,
             64'hFFFF_FFFF_FFFF_FFFF, 1'b0);
        step(1'b1, build_instr(OPC_SPECIAL, 5'h02, 5'h00, FN_SUB_TRAP), 64'h8000_0000_0000_0000, 64'h1, 1'b0);
        step(1'b1, build_instr(OPC_SPECIAL, 5'h02, 5'h00, FN_SUB_WRAP), 64'h8000_0000_0000_0000, 64'h1, 1'b0);
        step(1'b1, build_instr(OPC_SPECIAL, 5'h02, 5'h00, FN_SUB_TRAP), 64'h8000_0000_0000_0000, 64'h1, 1'b1);
        step(1'b1, build_instr(OPC_SPECIAL, 5'h01, 5'h03, FN_SHL_IMM), 64'h0, 64'h1234_5678_9ABC_DEF0, 1'b0);
        step(1'b1, build_instr(OPC_SPECIAL, 5'h00, 5'h03, 6'h3D), 64'h0, 64'h1234_5678_9ABC_DEF0, 1'b0);
        step(1'b1, build_instr(6'h01, 5'h00, 5'h00, FN_SUB_WRAP), 64'h5, 64'h3, 1'b0);
        $display("test overflow and refusal done");
        for (int n = 0; n < 400; n++) begin
            fn = fns[($random(seed) & 32'h7FFF_FFFF) % 11];
            step(($random(seed) & 7) != 0, build_instr(OPC_SPECIAL, (fn[5:3] == 3'b111) ? 5'h00 : 5'($random(seed)),
                 5'($random(seed)), fn), {$random(seed), $random(seed)}, {$random(seed), $random(seed)},
                 ($random(seed) & 7) == 0);
        end
        $display("test random traffic done");
        repeat (3) step(1'b0, 32'h0, 64'h0, 64'h0, 1'b0);
        `CHK(writes, exp_writes)
        `CHK(traps, exp_traps)
        `CHK(wr_sum, exp_sum)
        results();
    end
endmodule // tb

`default_nettype wire
